// ### rtl/simd_ext_gating_and_arith.sv
// Gating, control state tracking and add/shift datapath of the SIMD extension.
`timescale 1ns/100ps
`default_nettype none
module simd_ext_gating_and_arith #(
  parameter bit EXT_PRESENT = 1'b1,
  parameter bit REV2_PRESENT = 1'b1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic issue_valid_i,
  input wire simd_ext_pkg::op_t op_i,
  input wire logic rev2_required_i,
  input wire logic touches_state_i,
  input wire logic [1:0] acc_sel_i,
  input wire logic [31:0] status_word_i,
  input wire logic [2:0] architecture_release_field_i,
  input wire logic [31:0] src_a_i,
  input wire logic [31:0] src_b_i,
  input wire logic [4:0] shift_imm_i,
  input wire logic use_imm_i,
  input wire logic round_i,
  input wire logic sat_i,
  input wire logic [31:0] wr_data_i,
  input wire logic extract_fail_i,
  input wire logic [5:0] pos_new_i,
  input wire logic [3:0] cmp_cond_i,
  input wire logic [7:0] ovf_set_i,
  output logic [31:0] configuration_word_three_o,
  output logic rev3_supported_o,
  output logic reserved_instr_exc_o,
  output logic state_disabled_exc_o,
  output logic [4:0] exception_code_field_o,
  output logic arith_overflow_exc_o,
  output logic stall_o,
  output logic result_valid_o,
  output logic [31:0] result_o,
  output logic [1:0] acc_sel_o,
  output logic [31:0] extension_control_state_o
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Clamp a 17-bit signed sum to the Q15 range.
  function automatic logic [15:0] sat16(input logic [16:0] s);
    if (s[16] != s[15]) begin
      return s[16] ? 16'h8000 : 16'h7fff;
    end
    return s[15:0];
  endfunction

  // Clamp a 33-bit signed sum to the Q31 range.
  function automatic logic [31:0] sat32(input logic [32:0] s);
    if (s[32] != s[31]) begin
      return s[32] ? 32'h80000000 : 32'h7fffffff;
    end
    return s[31:0];
  endfunction

  // Sign-preserving right shift; rounding adds one at the top discarded bit.
  function automatic logic [32:0] sra_rnd(input logic [32:0] x, input logic [4:0] amt,
                                          input logic rnd);
    logic [33:0] t;
    t = 34'($signed({x[32], x}) >>> amt);
    if (rnd && amt != 5'h00) begin
      t = 34'($signed({x[32], x}) >>> (amt - 5'h01)) + 34'h000000001;
      t = 34'($signed(t) >>> 1);
    end
    return t[32:0];
  endfunction

  // Control state fields each operation reads.
  function automatic logic [31:0] read_mask(input simd_ext_pkg::op_t op);
    case (op)
      simd_ext_pkg::OP_RDCTL: return simd_ext_pkg::MASK_ALL;
      simd_ext_pkg::OP_BRANCH_POS,
      simd_ext_pkg::OP_EXTRACT,
      simd_ext_pkg::OP_EXTRACT_DP: return simd_ext_pkg::MASK_POS;
      simd_ext_pkg::OP_VAR_INSERT: return simd_ext_pkg::MASK_POS | simd_ext_pkg::MASK_SCOUNT;
      simd_ext_pkg::OP_PICK: return simd_ext_pkg::MASK_CCOND;
      default: return simd_ext_pkg::MASK_NONE;
    endcase
  endfunction

  // Control state fields each operation writes.
  function automatic logic [31:0] write_mask(input simd_ext_pkg::op_t op);
    case (op)
      simd_ext_pkg::OP_WRCTL: return simd_ext_pkg::MASK_ALL;
      simd_ext_pkg::OP_EXTRACT: return simd_ext_pkg::MASK_FAIL;
      simd_ext_pkg::OP_EXTRACT_DP: return simd_ext_pkg::MASK_FAIL | simd_ext_pkg::MASK_POS;
      simd_ext_pkg::OP_SHIFT_INSERT: return simd_ext_pkg::MASK_POS;
      simd_ext_pkg::OP_COMPARE: return simd_ext_pkg::MASK_CCOND;
      simd_ext_pkg::OP_ADDQ_PH, simd_ext_pkg::OP_SUBQ_PH, simd_ext_pkg::OP_ADDQ_W,
      simd_ext_pkg::OP_SUBQ_W, simd_ext_pkg::OP_ADDU_QB, simd_ext_pkg::OP_ADDU_PH,
      simd_ext_pkg::OP_SHRA_PH, simd_ext_pkg::OP_SHRA_W: return simd_ext_pkg::MASK_OUFLAG;
      default: return simd_ext_pkg::MASK_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_wb_reg;
  logic [31:0] ctrl_wb_next;
  logic wb_pend_reg;
  logic [31:0] wb_mask_reg;
  logic [31:0] rmask;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic ext_bit;
  logic rev2_bit;
  logic needs_ext;
  logic needs_rev2;
  logic reserved;
  logic disabled;
  logic hazard;
  logic accepted;
  logic [31:0] res;

  // Presence bits are parameters, so no write path can reach them.
  assign ext_bit = EXT_PRESENT;
  assign rev2_bit = REV2_PRESENT & EXT_PRESENT;
  assign extension_control_state_o = ctrl_reg;

  // ----------------------------------------------------------------
  // Gating and interlock
  // ----------------------------------------------------------------
  // A move to accumulator zero is an ordinary move and is gated only when touches_state_i is set.
  always_comb begin
    needs_ext = (op_i != simd_ext_pkg::OP_NOP && op_i != simd_ext_pkg::OP_ACC_MOVE)
              || (op_i == simd_ext_pkg::OP_ACC_MOVE && acc_sel_i != 2'h0)
              || touches_state_i;
    needs_rev2 = rev2_required_i || op_i == simd_ext_pkg::OP_ADDUH_QB
              || op_i == simd_ext_pkg::OP_ADDU_PH || op_i == simd_ext_pkg::OP_ADDQH_PH
              || op_i == simd_ext_pkg::OP_ADDQH_W;
    reserved = issue_valid_i && needs_ext && (!ext_bit || (needs_rev2 && !rev2_bit));
    disabled = issue_valid_i && needs_ext && !reserved
             && !status_word_i[simd_ext_pkg::STATUS_ENABLE_POS];
    rmask = read_mask(op_i);
    wmask = write_mask(op_i);
    // Every write merges into the committed value, so any write also waits on a pending one.
    hazard = issue_valid_i && wb_pend_reg
           && ((rmask & wb_mask_reg) != simd_ext_pkg::MASK_NONE
               || wmask != simd_ext_pkg::MASK_NONE);
    accepted = issue_valid_i && !hazard && !reserved && !disabled;
  end

  // ----------------------------------------------------------------
  // Control state next value
  // ----------------------------------------------------------------
  // Overflow flags only ever gain bits here; an explicit write is the only clear.
  always_comb begin
    wval = ctrl_reg;
    wval[simd_ext_pkg::POS_LSB +: 6] = pos_new_i;
    wval[simd_ext_pkg::FAIL_POS] = extract_fail_i;
    wval[simd_ext_pkg::OUFLAG_LSB +: 8] = ctrl_reg[simd_ext_pkg::OUFLAG_LSB +: 8] | ovf_set_i;
    wval[simd_ext_pkg::CCOND_LSB +: 4] = cmp_cond_i;
    if (op_i == simd_ext_pkg::OP_WRCTL) begin
      wval = wr_data_i;
    end
    ctrl_wb_next = (ctrl_reg & ~wmask) | (wval & wmask);
  end

  // ----------------------------------------------------------------
  // Element datapath
  // ----------------------------------------------------------------
  always_comb begin
    logic [16:0] h;
    logic [32:0] w;
    logic [8:0] b;
    logic [4:0] amt;
    h = '0;
    w = '0;
    b = '0;
    amt = use_imm_i ? shift_imm_i : src_b_i[4:0];
    res = '0;
    case (op_i)
      simd_ext_pkg::OP_ADDQ_PH, simd_ext_pkg::OP_SUBQ_PH: begin
        for (int i = 0; i < 2; i++) begin
          h = (op_i == simd_ext_pkg::OP_SUBQ_PH)
            ? {src_a_i[16*i+15], src_a_i[16*i +: 16]} - {src_b_i[16*i+15], src_b_i[16*i +: 16]}
            : {src_a_i[16*i+15], src_a_i[16*i +: 16]} + {src_b_i[16*i+15], src_b_i[16*i +: 16]};
          res[16*i +: 16] = sat_i ? sat16(h) : h[15:0];
        end
      end
      simd_ext_pkg::OP_ADDQ_W: begin
        w = {src_a_i[31], src_a_i} + {src_b_i[31], src_b_i};
        res = sat32(w);
      end
      simd_ext_pkg::OP_SUBQ_W: begin
        w = {src_a_i[31], src_a_i} - {src_b_i[31], src_b_i};
        res = sat32(w);
      end
      simd_ext_pkg::OP_ADDU_QB: begin
        for (int i = 0; i < 4; i++) begin
          b = {1'b0, src_a_i[8*i +: 8]} + {1'b0, src_b_i[8*i +: 8]};
          res[8*i +: 8] = (sat_i && b[8]) ? 8'hff : b[7:0];
        end
      end
      simd_ext_pkg::OP_ADDUH_QB: begin
        for (int i = 0; i < 4; i++) begin
          b = {1'b0, src_a_i[8*i +: 8]} + {1'b0, src_b_i[8*i +: 8]} + {8'h00, round_i};
          res[8*i +: 8] = b[8:1];
        end
      end
      simd_ext_pkg::OP_ADDU_PH: begin
        for (int i = 0; i < 2; i++) begin
          h = {1'b0, src_a_i[16*i +: 16]} + {1'b0, src_b_i[16*i +: 16]};
          res[16*i +: 16] = (sat_i && h[16]) ? 16'hffff : h[15:0];
        end
      end
      simd_ext_pkg::OP_ADDQH_PH: begin
        for (int i = 0; i < 2; i++) begin
          h = {src_a_i[16*i+15], src_a_i[16*i +: 16]} + {src_b_i[16*i+15], src_b_i[16*i +: 16]}
            + {16'h0000, round_i};
          res[16*i +: 16] = h[16:1];
        end
      end
      simd_ext_pkg::OP_ADDQH_W: begin
        w = {src_a_i[31], src_a_i} + {src_b_i[31], src_b_i} + {32'h00000000, round_i};
        res = w[32:1];
      end
      simd_ext_pkg::OP_SHRA_PH: begin
        for (int i = 0; i < 2; i++) begin
          w = sra_rnd({{17{src_a_i[16*i+15]}}, src_a_i[16*i +: 16]}, {1'b0, amt[3:0]}, round_i);
          res[16*i +: 16] = w[15:0];
        end
      end
      simd_ext_pkg::OP_SHRA_W: begin
        w = sra_rnd({src_a_i[31], src_a_i}, amt, round_i);
        res = w[31:0];
      end
      simd_ext_pkg::OP_RDCTL: begin
        res = ctrl_reg;
      end
      default: begin
        res = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Control state and its one-stage write-back
  // ----------------------------------------------------------------
  // Writes land one cycle after acceptance; the interlock covers that window.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ctrl_reg <= simd_ext_pkg::CTRL_RESET;
      ctrl_wb_reg <= simd_ext_pkg::CTRL_RESET;
      wb_pend_reg <= 1'b0;
      wb_mask_reg <= simd_ext_pkg::MASK_NONE;
    end else begin
      if (wb_pend_reg) begin
        ctrl_reg <= ctrl_wb_reg;
      end
      wb_pend_reg <= accepted && wmask != simd_ext_pkg::MASK_NONE;
      wb_mask_reg <= accepted ? wmask : simd_ext_pkg::MASK_NONE;
      ctrl_wb_reg <= ctrl_wb_next;
    end
  end

  // ----------------------------------------------------------------
  // Exception and result outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      reserved_instr_exc_o <= 1'b0;
      state_disabled_exc_o <= 1'b0;
      exception_code_field_o <= simd_ext_pkg::EXC_NONE;
      arith_overflow_exc_o <= 1'b0;
      stall_o <= 1'b0;
      result_valid_o <= 1'b0;
      result_o <= '0;
      acc_sel_o <= 2'h0;
    end else begin
      reserved_instr_exc_o <= reserved;
      state_disabled_exc_o <= disabled;
      exception_code_field_o <= reserved ? simd_ext_pkg::EXC_RESERVED
                              : disabled ? simd_ext_pkg::EXC_STATE_DISABLED
                              : simd_ext_pkg::EXC_NONE;
      arith_overflow_exc_o <= 1'b0;
      stall_o <= hazard && !reserved && !disabled;
      result_valid_o <= accepted;
      result_o <= accepted ? res : '0;
      if (accepted) begin
        acc_sel_o <= acc_sel_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capability reporting
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      configuration_word_three_o <= '0;
      rev3_supported_o <= 1'b0;
    end else begin
      configuration_word_three_o <= '0;
      configuration_word_three_o[simd_ext_pkg::EXT_PRESENT_POS] <= ext_bit;
      configuration_word_three_o[simd_ext_pkg::REV2_PRESENT_POS] <= rev2_bit;
      rev3_supported_o <= ext_bit && rev2_bit
                        && architecture_release_field_i >= simd_ext_pkg::REV3_MIN_RELEASE;
    end
  end
endmodule
`default_nettype wire

// ### rtl/simd_ext_pkg.sv
// Constants, field layout and operation codes of the SIMD extension gating and arithmetic block.
package simd_ext_pkg;
  // ----------------------------------------------------------------
  // Capability and status bit positions, revision-3 release threshold and exception codes
  // ----------------------------------------------------------------
  localparam int EXT_PRESENT_POS = 10;
  localparam int REV2_PRESENT_POS = 11;
  localparam int STATUS_ENABLE_POS = 24;
  localparam logic [2:0] REV3_MIN_RELEASE = 3'h2;
  localparam logic [4:0] EXC_NONE = 5'h00;
  localparam logic [4:0] EXC_RESERVED = 5'h0a;
  localparam logic [4:0] EXC_STATE_DISABLED = 5'h1a;
  // ----------------------------------------------------------------
  // Control state field layout and reset value
  // ----------------------------------------------------------------
  localparam int POS_LSB = 0;
  localparam int SCOUNT_LSB = 7;
  localparam int FAIL_POS = 14;
  localparam int OUFLAG_LSB = 16;
  localparam int CCOND_LSB = 24;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] MASK_POS = 32'h0000003f;
  localparam logic [31:0] MASK_SCOUNT = 32'h00001f80;
  localparam logic [31:0] MASK_FAIL = 32'h00004000;
  localparam logic [31:0] MASK_OUFLAG = 32'h00ff0000;
  localparam logic [31:0] MASK_CCOND = 32'h0f000000;
  localparam logic [31:0] MASK_ALL = 32'hffffffff;
  localparam logic [31:0] MASK_NONE = 32'h00000000;
  // ----------------------------------------------------------------
  // Operations presented by decode
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_ACC_MOVE, OP_WRCTL, OP_RDCTL, OP_EXTRACT, OP_EXTRACT_DP,
    OP_SHIFT_INSERT, OP_VAR_INSERT, OP_BRANCH_POS, OP_COMPARE, OP_PICK,
    OP_ADDQ_PH, OP_SUBQ_PH, OP_ADDQ_W, OP_SUBQ_W, OP_ADDU_QB, OP_ADDUH_QB,
    OP_ADDU_PH, OP_ADDQH_PH, OP_ADDQH_W, OP_SHRA_PH, OP_SHRA_W
  } op_t;
endpackage

// ### sim/core_status_model.sv
// Model of the core's status word and release field as seen by the extension block.
`timescale 1ns/100ps
`default_nettype none
module core_status_model (
  input wire logic enable_i,
  input wire logic [2:0] release_i,
  output logic [31:0] status_word_o,
  output logic [2:0] release_o
);
  // Unrelated status bits are kept busy so that only bit 24 may decide the gating.
  assign status_word_o = {7'h55, enable_i, 24'ha5ff13};
  assign release_o = release_i;
endmodule
`default_nettype wire

// ### sim/simd_ext_gating_and_arith_checker.sv
// Port-level assertions for the SIMD extension gating and arithmetic block.
`timescale 1ns/100ps
`default_nettype none
module simd_ext_gating_and_arith_checker #(
  parameter bit EXT_PRESENT = 1'b1,
  parameter bit REV2_PRESENT = 1'b1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic issue_valid_i,
  input wire simd_ext_pkg::op_t op_i,
  input wire logic rev2_required_i,
  input wire logic touches_state_i,
  input wire logic [1:0] acc_sel_i,
  input wire logic [31:0] status_word_i,
  input wire logic [2:0] architecture_release_field_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [31:0] configuration_word_three_o,
  input wire logic rev3_supported_o,
  input wire logic reserved_instr_exc_o,
  input wire logic state_disabled_exc_o,
  input wire logic [4:0] exception_code_field_o,
  input wire logic arith_overflow_exc_o,
  input wire logic stall_o,
  input wire logic result_valid_o,
  input wire logic [31:0] extension_control_state_o
);
  // ----------------------------------------------------------------
  // Assertions, all in the core clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Capability bits are fixed; the first edge after reset is skipped while they load.
  AST_CFG_BITS: assert property ($past(nrst_i) |->
    configuration_word_three_o == {20'h0, REV2_PRESENT & EXT_PRESENT, EXT_PRESENT, 10'h0})
    else $error("capability bits wrong");
  AST_REV3: assert property ($past(nrst_i) |-> rev3_supported_o == (EXT_PRESENT && REV2_PRESENT &&
    $past(architecture_release_field_i) >= simd_ext_pkg::REV3_MIN_RELEASE))
    else $error("revision 3 flag wrong");
  AST_DISABLED: assert property (issue_valid_i && EXT_PRESENT && !status_word_i[24] && !rev2_required_i &&
    (op_i == simd_ext_pkg::OP_ADDQ_PH || touches_state_i || (op_i == simd_ext_pkg::OP_ACC_MOVE && acc_sel_i != 2'h0))
    |=> state_disabled_exc_o && exception_code_field_o == simd_ext_pkg::EXC_STATE_DISABLED && !result_valid_o)
    else $error("disabled access not trapped");
  AST_RESERVED: assert property (issue_valid_i && rev2_required_i && !REV2_PRESENT &&
    op_i != simd_ext_pkg::OP_NOP && (op_i != simd_ext_pkg::OP_ACC_MOVE || acc_sel_i != 2'h0) |=>
    reserved_instr_exc_o && exception_code_field_o == simd_ext_pkg::EXC_RESERVED && !result_valid_o)
    else $error("missing revision not trapped");
  AST_NO_ARITH_EXC: assert property (!arith_overflow_exc_o)
    else $error("arithmetic exception raised");
  AST_WR_COMMIT: assert property (result_valid_o && $past(op_i) == simd_ext_pkg::OP_WRCTL |=>
    extension_control_state_o == $past(wr_data_i, 2))
    else $error("control write not committed");
  AST_RAW_STALL: assert property (result_valid_o && $past(op_i) == simd_ext_pkg::OP_WRCTL && issue_valid_i &&
    op_i == simd_ext_pkg::OP_RDCTL && status_word_i[24] && !touches_state_i |=> stall_o && !result_valid_o)
    else $error("read after write not stalled");
  AST_EXC_NO_WRITE: assert property (state_disabled_exc_o |=> $stable(extension_control_state_o))
    else $error("trapped op changed control state");
  // Overflow flags may only fall on the commit of an explicit control write.
  AST_STICKY: assert property (!($past(result_valid_o) && $past(op_i, 2) == simd_ext_pkg::OP_WRCTL) |->
    (extension_control_state_o[23:16] & $past(extension_control_state_o[23:16])) ==
    $past(extension_control_state_o[23:16]))
    else $error("overflow flag lost");
  COV_STALL: cover property (stall_o);
  COV_DISABLED: cover property (state_disabled_exc_o);
  COV_RESERVED: cover property (reserved_instr_exc_o);
endmodule
bind simd_ext_gating_and_arith simd_ext_gating_and_arith_checker #(
  .EXT_PRESENT(EXT_PRESENT),
  .REV2_PRESENT(REV2_PRESENT)
) chk_i (.*);
`default_nettype wire

// ### sim/tb_simd_ext_gating_and_arith.sv
// Self-checking testbench of the SIMD extension gating and arithmetic block.
`timescale 1ns/100ps
`default_nettype none
module tb_simd_ext_gating_and_arith;
  logic clock_i, nrst_i, issue_valid_i, rev2_required_i, touches_state_i, use_imm_i, round_i, sat_i;
  logic extract_fail_i, stall_o, result_valid_o, rev3_supported_o, reserved_instr_exc_o;
  logic state_disabled_exc_o, arith_overflow_exc_o, en, r2_exc;
  simd_ext_pkg::op_t op_i;
  logic [1:0] acc_sel_i, acc_sel_o;
  logic [2:0] rel, architecture_release_field_i;
  logic [3:0] cmp_cond_i;
  logic [4:0] shift_imm_i, exception_code_field_o, r2_code;
  logic [5:0] pos_new_i;
  logic [7:0] ovf_set_i;
  logic [31:0] status_word_i, src_a_i, src_b_i, wr_data_i, configuration_word_three_o, result_o;
  logic [31:0] extension_control_state_o, r2_cfg;
  int n_errors = 0;
  int check_count = 0;
  // ----------------------------------------------------------------
  // Design, a revision-1 twin and the core model
  // ----------------------------------------------------------------
  simd_ext_gating_and_arith uut (.*);
  simd_ext_gating_and_arith #(.REV2_PRESENT(1'b0)) uut2 (.*, .configuration_word_three_o(r2_cfg),
    .rev3_supported_o(), .reserved_instr_exc_o(r2_exc), .state_disabled_exc_o(), .exception_code_field_o(r2_code),
    .arith_overflow_exc_o(), .stall_o(), .result_valid_o(), .result_o(), .acc_sel_o(), .extension_control_state_o());
  core_status_model core (.enable_i(en), .release_i(rel), .status_word_o(status_word_i),
    .release_o(architecture_release_field_i));
  // Free-running core clock at 100 MHz.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One idle cycle before each issue keeps a pending write from stalling the next op.
  task automatic go(input simd_ext_pkg::op_t op, input logic [31:0] a, input logic [31:0] b,
    input logic [4:0] imm, input logic [2:0] fl);
    @(posedge clock_i) #1;
    op_i = op;
    src_a_i = a;
    src_b_i = b;
    shift_imm_i = imm;
    {round_i, sat_i, use_imm_i} = fl;
    issue_valid_i = 1'b1;
    @(posedge clock_i) #1;
    issue_valid_i = 1'b0;
  endtask
  task automatic ar(input simd_ext_pkg::op_t op, input logic [31:0] a, input logic [31:0] b,
    input logic [4:0] imm, input logic [2:0] fl, input logic [31:0] exp);
    go(op, a, b, imm, fl);
    chk({result_valid_o, arith_overflow_exc_o}, 2'b10);
    chk(result_o, exp);
  endtask
  task automatic ctl(input logic [31:0] exp);
    @(posedge clock_i) #1;
    chk(extension_control_state_o, exp);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg;
    repeat (2) @(posedge clock_i);
    #1;
    chk(configuration_word_three_o, 32'h00000c00);
    chk(r2_cfg, 32'h00000400);
    chk(rev3_supported_o, 1'b1);
    rel = 3'h1;
    repeat (2) @(posedge clock_i);
    #1;
    chk(rev3_supported_o, 1'b0);
  endtask
  // Flags are {round, saturate, immediate amount}.
  task automatic t_arith;
    ar(simd_ext_pkg::OP_ADDQ_PH, 32'h7fff8000, 32'h0001ffff, 5'h0, 3'b010, 32'h7fff8000);
    ar(simd_ext_pkg::OP_ADDQ_PH, 32'h7fff8000, 32'h0001ffff, 5'h0, 3'b000, 32'h80007fff);
    ar(simd_ext_pkg::OP_SUBQ_PH, 32'h80007fff, 32'h0001ffff, 5'h0, 3'b010, 32'h80007fff);
    ar(simd_ext_pkg::OP_ADDQ_W, 32'h7fffffff, 32'h00000001, 5'h0, 3'b000, 32'h7fffffff);
    ar(simd_ext_pkg::OP_SUBQ_W, 32'h80000000, 32'h00000001, 5'h0, 3'b000, 32'h80000000);
    ar(simd_ext_pkg::OP_ADDU_QB, 32'hff010203, 32'h01010101, 5'h0, 3'b010, 32'hff020304);
    ar(simd_ext_pkg::OP_ADDU_QB, 32'hff010203, 32'h01010101, 5'h0, 3'b000, 32'h00020304);
    ar(simd_ext_pkg::OP_ADDUH_QB, 32'hff01ff01, 32'hff02ff02, 5'h0, 3'b100, 32'hff02ff02);
    ar(simd_ext_pkg::OP_ADDUH_QB, 32'hff01ff01, 32'hff02ff02, 5'h0, 3'b000, 32'hff01ff01);
    ar(simd_ext_pkg::OP_ADDU_PH, 32'hffff0001, 32'h00010001, 5'h0, 3'b010, 32'hffff0002);
    ar(simd_ext_pkg::OP_ADDQH_PH, 32'h7fffffff, 32'h0000fffe, 5'h0, 3'b100, 32'h4000ffff);
    ar(simd_ext_pkg::OP_ADDQH_PH, 32'h7fffffff, 32'h0000fffe, 5'h0, 3'b000, 32'h3ffffffe);
    ar(simd_ext_pkg::OP_ADDQH_W, 32'h7fffffff, 32'h00000002, 5'h0, 3'b100, 32'h40000001);
    ar(simd_ext_pkg::OP_SHRA_PH, 32'h80000007, 32'h00000011, 5'h0, 3'b100, 32'hc0000004);
    ar(simd_ext_pkg::OP_SHRA_PH, 32'h80000007, 32'h0, 5'h2, 3'b001, 32'he0000001);
    ar(simd_ext_pkg::OP_SHRA_W, 32'h80000007, 32'h00000021, 5'h0, 3'b000, 32'hc0000003);
    ar(simd_ext_pkg::OP_SHRA_W, 32'h80000007, 32'h0, 5'h3, 3'b101, 32'hf0000001);
  endtask
  task automatic t_ctrl;
    @(posedge clock_i) #1;
    op_i = simd_ext_pkg::OP_WRCTL;
    wr_data_i = 32'h0a007fbf;
    issue_valid_i = 1'b1;
    @(posedge clock_i) #1;
    chk(result_valid_o, 1'b1);
    op_i = simd_ext_pkg::OP_RDCTL;
    @(posedge clock_i) #1;
    chk({stall_o, result_valid_o}, 2'b10);
    @(posedge clock_i) #1;
    chk(result_o, 32'h0a007fbf);
    issue_valid_i = 1'b0;
    ovf_set_i = 8'h21;
    go(simd_ext_pkg::OP_ADDQ_PH, 32'h0, 32'h0, 5'h0, 3'b000);
    ovf_set_i = 8'h00;
    go(simd_ext_pkg::OP_ADDQ_PH, 32'h0, 32'h0, 5'h0, 3'b000);
    ctl(32'h0a217fbf);
    go(simd_ext_pkg::OP_EXTRACT_DP, 32'h0, 32'h0, 5'h0, 3'b000);
    ctl(32'h0a213f85);
    go(simd_ext_pkg::OP_COMPARE, 32'h0, 32'h0, 5'h0, 3'b000);
    ctl(32'h06213f85);
    pos_new_i = 6'h2a;
    go(simd_ext_pkg::OP_SHIFT_INSERT, 32'h0, 32'h0, 5'h0, 3'b000);
    ctl(32'h06213faa);
    extract_fail_i = 1'b1;
    go(simd_ext_pkg::OP_EXTRACT, 32'h0, 32'h0, 5'h0, 3'b000);
    ctl(32'h06217faa);
    extract_fail_i = 1'b0;
    wr_data_i = 32'h0;
    go(simd_ext_pkg::OP_WRCTL, 32'h0, 32'h0, 5'h0, 3'b000);
    ctl(32'h0);
  endtask
  // A position reader right after a position writer is held once; a condition reader is not.
  task automatic t_fields;
    @(posedge clock_i) #1;
    op_i = simd_ext_pkg::OP_SHIFT_INSERT;
    issue_valid_i = 1'b1;
    @(posedge clock_i) #1;
    op_i = simd_ext_pkg::OP_BRANCH_POS;
    @(posedge clock_i) #1;
    chk({stall_o, result_valid_o}, 2'b10);
    @(posedge clock_i) #1;
    chk({stall_o, result_valid_o}, 2'b01);
    op_i = simd_ext_pkg::OP_SHIFT_INSERT;
    @(posedge clock_i) #1;
    op_i = simd_ext_pkg::OP_PICK;
    @(posedge clock_i) #1;
    chk({stall_o, result_valid_o}, 2'b01);
    issue_valid_i = 1'b0;
  endtask
  task automatic t_gate;
    en = 1'b0;
    go(simd_ext_pkg::OP_ADDQ_PH, 32'h1, 32'h1, 5'h0, 3'b000);
    chk({state_disabled_exc_o, exception_code_field_o, result_valid_o}, 7'h74);
    acc_sel_i = 2'h2;
    go(simd_ext_pkg::OP_ACC_MOVE, 32'h1, 32'h1, 5'h0, 3'b000);
    chk({state_disabled_exc_o, exception_code_field_o, result_valid_o}, 7'h74);
    acc_sel_i = 2'h0;
    go(simd_ext_pkg::OP_ACC_MOVE, 32'h1, 32'h1, 5'h0, 3'b000);
    chk({state_disabled_exc_o, result_valid_o, acc_sel_o}, 4'h4);
    touches_state_i = 1'b1;
    go(simd_ext_pkg::OP_NOP, 32'h0, 32'h0, 5'h0, 3'b000);
    chk({state_disabled_exc_o, exception_code_field_o}, 6'h3a);
    touches_state_i = 1'b0;
    en = 1'b1;
    acc_sel_i = 2'h3;
    rev2_required_i = 1'b1;
    go(simd_ext_pkg::OP_ACC_MOVE, 32'h1, 32'h1, 5'h0, 3'b000);
    chk({reserved_instr_exc_o, r2_exc, r2_code, result_valid_o, acc_sel_o}, 10'h157);
    rev2_required_i = 1'b0;
  endtask
  // Main sequence: inputs at time zero, reset for four cycles, then every scenario.
  initial begin
    {nrst_i, issue_valid_i, rev2_required_i, touches_state_i, use_imm_i, round_i, sat_i, extract_fail_i} = 8'h0;
    op_i = simd_ext_pkg::OP_NOP;
    {acc_sel_i, shift_imm_i, src_a_i, src_b_i, wr_data_i, cmp_cond_i, ovf_set_i} = '0;
    pos_new_i = 6'h05;
    cmp_cond_i = 4'h6;
    en = 1'b1;
    rel = 3'h2;
    repeat (4) @(posedge clock_i);
    #1;
    nrst_i = 1'b1;
    t_cfg();
    t_arith();
    t_ctrl();
    t_fields();
    t_gate();
    test_done();
  end
  // The scenarios need well under a thousand cycles.
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
